// ==== rtl/alt_function_router.v ====
// Alternate function pin router: registers, event output and peripheral pin steering
//
// Function
// - Audio serial data pin is input when the audio peripheral receives.
// - Audio master clock pin is released to GPIO in audio slave mode.
// - CAN receive pin feeds CAN input; CAN transmit driven push-pull.
// - USB data pins join the internal transceiver once USB is enabled.
// - Alternate function active once its peripheral enables; default after reset.
// - Slow crystal pins act as port C 14/15 only with oscillator off.
// - Port D 0/1 remapped to main crystal pins raise no interrupt events.
// - Seven registers decoded, offsets 0x00 through 0x18.
// - Bits 3:0 pick event output pin 0 to 15, binary.
// - Bits 6:4 pick ports A to G; code 111 reserved.
// - Bit 7 gates the core event output onto the chosen pin.
`timescale 1ns/10ps
`include "alt_function_router_defines.vh"
module alt_function_router #(
  parameter NUM_PORTS = 7
) (
  // Clock and reset
  input  wire                    ref_clk,
  input  wire                    rst_n,
  // Register port, word access only
  input  wire                    bus_clk_en,
  input  wire                    reg_sel,
  input  wire                    reg_write,
  input  wire [4:0]              reg_addr,
  input  wire [31:0]             reg_wdata,
  output reg  [31:0]             reg_rdata,
  output reg                     reg_ready,
  output reg                     reg_error,
  // Core event
  input  wire                    core_event_signal,
  output reg  [NUM_PORTS*16-1:0] event_pin_out,
  output reg  [NUM_PORTS*16-1:0] event_pin_oe,
  // Audio serial peripheral
  input  wire                    audio_enable,
  input  wire                    audio_master_mode,
  input  wire                    audio_transmit,
  input  wire                    audio_master_clock,
  input  wire                    audio_data_out,
  input  wire                    audio_serial_data_pin_in,
  output reg                     audio_serial_data_pin_out,
  output reg                     audio_serial_data_pin_oe,
  output reg                     audio_data_in,
  output reg                     audio_master_clock_pin_out,
  output reg                     audio_master_clock_pin_oe,
  output reg                     audio_master_clock_pin_free,
  // CAN peripheral
  input  wire                    can_enable,
  input  wire                    can_tx,
  input  wire                    can_rx_pin_in,
  output reg                     can_rx,
  output reg                     can_tx_pin_out,
  output reg                     can_tx_pin_oe,
  // USB device module
  input  wire                    usb_device_module_enable,
  output reg                     usb_pins_to_transceiver,
  // Oscillators
  input  wire                    low_speed_crystal_clock_on,
  output reg                     slow_crystal_pins_gpio,
  output reg                     main_crystal_pins_port_d,
  input  wire [1:0]              port_d_low_irq_in,
  output reg  [1:0]              port_d_low_irq_out,
  // Remap and interrupt selection contents
  output reg  [31:0]             remap_first,
  output reg  [31:0]             remap_second,
  output reg  [127:0]            ext_irq_select
);
  reg  [31:0]             event_out_control;
  wire [NUM_PORTS*16-1:0] next_event_pin_out;
  wire [NUM_PORTS*16-1:0] next_event_pin_oe;
  reg  [31:0]             next_rdata;
  reg                     addr_hit;
  wire                    access;
  wire                    wr;

  // Accesses without the bus clock are not seen; the register stays put
  assign access = reg_sel & bus_clk_en;
  assign wr     = access & reg_write & addr_hit;

  // Address decode and read mux
  always @* begin
    addr_hit   = 1'b1;
    next_rdata = 32'h0000_0000;
    case (reg_addr)
      `OFS_EVENT_OUT_CONTROL:   next_rdata = event_out_control & `EVT_CTRL_MASK;
      `OFS_REMAP_CONFIG_FIRST:  next_rdata = remap_first;
      `OFS_EXT_IRQ_SELECT_A:    next_rdata = ext_irq_select[31:0];
      `OFS_EXT_IRQ_SELECT_B:    next_rdata = ext_irq_select[63:32];
      `OFS_EXT_IRQ_SELECT_C:    next_rdata = ext_irq_select[95:64];
      `OFS_EXT_IRQ_SELECT_D:    next_rdata = ext_irq_select[127:96];
      `OFS_REMAP_CONFIG_SECOND: next_rdata = remap_second;
      default:                  addr_hit   = 1'b0;
    endcase
  end

  // Register writes; a one-cycle ready answers every taken access
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      event_out_control <= `RST_EVENT_OUT_CONTROL;
      remap_first       <= `RST_REMAP;
      remap_second      <= `RST_REMAP;
      ext_irq_select    <= {4{`RST_EXT_IRQ_SELECT}};
      reg_rdata         <= 32'h0000_0000;
      reg_ready         <= 1'b0;
      reg_error         <= 1'b0;
    end else begin
      reg_ready <= access;
      reg_error <= access & ~addr_hit;
      reg_rdata <= (access & ~reg_write) ? next_rdata : 32'h0000_0000;
      if (wr) begin
        case (reg_addr)
          `OFS_EVENT_OUT_CONTROL:   event_out_control <= reg_wdata & `EVT_CTRL_MASK;
          `OFS_REMAP_CONFIG_FIRST:  remap_first <= reg_wdata;
          `OFS_EXT_IRQ_SELECT_A:    ext_irq_select[31:0] <= reg_wdata;
          `OFS_EXT_IRQ_SELECT_B:    ext_irq_select[63:32] <= reg_wdata;
          `OFS_EXT_IRQ_SELECT_C:    ext_irq_select[95:64] <= reg_wdata;
          `OFS_EXT_IRQ_SELECT_D:    ext_irq_select[127:96] <= reg_wdata;
          `OFS_REMAP_CONFIG_SECOND: remap_second <= reg_wdata;
          default:                  remap_second <= remap_second;
        endcase
      end
    end
  end

  // One decoder per port; code 111 matches none of them
  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p = p + 1) begin : g_port
      // A genvar cannot be part-selected, so its code passes through a sized constant
      localparam [31:0] port_code_wide = p;
      event_port_decoder #(
        .PORT_CODE (port_code_wide[2:0])
      ) u_dec (
        .gate        (event_out_control[`EVT_GATE_BIT]),
        .port_index  (event_out_control[`EVT_PORT_MSB:`EVT_PORT_LSB]),
        .pin_index   (event_out_control[`EVT_PIN_MSB:`EVT_PIN_LSB]),
        .event_level (core_event_signal),
        .pin_out     (next_event_pin_out[p*16 +: 16]),
        .pin_oe      (next_event_pin_oe[p*16 +: 16])
      );
    end
  endgenerate

  // Pin steering is registered so every output leaves a flip-flop
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      event_pin_out               <= {NUM_PORTS*16{1'b0}};
      event_pin_oe                <= {NUM_PORTS*16{1'b0}};
      audio_serial_data_pin_out   <= 1'b0;
      audio_serial_data_pin_oe    <= 1'b0;
      audio_data_in               <= 1'b0;
      audio_master_clock_pin_out  <= 1'b0;
      audio_master_clock_pin_oe   <= 1'b0;
      audio_master_clock_pin_free <= 1'b1;
      can_rx                      <= 1'b1;
      can_tx_pin_out              <= 1'b1;
      can_tx_pin_oe               <= 1'b0;
      usb_pins_to_transceiver     <= 1'b0;
      slow_crystal_pins_gpio      <= 1'b1;
      main_crystal_pins_port_d    <= 1'b0;
      port_d_low_irq_out          <= 2'b00;
    end else begin
      event_pin_out <= next_event_pin_out;
      event_pin_oe  <= next_event_pin_oe;
      // Pins hold their default function until the peripheral enables
      audio_serial_data_pin_oe   <= audio_enable & audio_transmit;
      audio_serial_data_pin_out  <= audio_enable & audio_transmit & audio_data_out;
      audio_data_in              <= audio_enable & ~audio_transmit & audio_serial_data_pin_in;
      audio_master_clock_pin_oe  <= audio_enable & audio_master_mode;
      audio_master_clock_pin_out <= audio_enable & audio_master_mode & audio_master_clock;
      audio_master_clock_pin_free <= ~(audio_enable & audio_master_mode);
      can_rx                     <= can_enable ? can_rx_pin_in : 1'b1;
      can_tx_pin_oe              <= can_enable;
      can_tx_pin_out             <= can_enable ? can_tx : 1'b1;
      usb_pins_to_transceiver    <= usb_device_module_enable;
      slow_crystal_pins_gpio     <= ~low_speed_crystal_clock_on;
      main_crystal_pins_port_d   <= remap_second[`REMAP2_OSC_TO_PD_BIT];
      // Remapped port D pins are cut from the interrupt lines
      port_d_low_irq_out <= remap_second[`REMAP2_OSC_TO_PD_BIT] ? 2'b00 : port_d_low_irq_in;
    end
  end
endmodule // alt_function_router

// ==== rtl/alt_function_router_defines.vh ====
// Register offsets, field positions and reset values of the pin router
`ifndef ALT_FUNCTION_ROUTER_DEFINES_VH
`define ALT_FUNCTION_ROUTER_DEFINES_VH
`define OFS_EVENT_OUT_CONTROL     5'h00
`define OFS_REMAP_CONFIG_FIRST    5'h04
`define OFS_EXT_IRQ_SELECT_A      5'h08
`define OFS_EXT_IRQ_SELECT_B      5'h0c
`define OFS_EXT_IRQ_SELECT_C      5'h10
`define OFS_EXT_IRQ_SELECT_D      5'h14
`define OFS_REMAP_CONFIG_SECOND   5'h18
`define RST_EVENT_OUT_CONTROL     32'h0000_0000
`define RST_REMAP                 32'h0000_0000
`define RST_EXT_IRQ_SELECT        32'h0000_0000
`define EVT_PIN_LSB               0
`define EVT_PIN_MSB               3
`define EVT_PORT_LSB              4
`define EVT_PORT_MSB              6
`define EVT_GATE_BIT              7
`define EVT_PORT_RESERVED         3'h7
`define EVT_CTRL_MASK             32'h0000_00ff
`define REMAP2_OSC_TO_PD_BIT      0
`endif

// ==== rtl/event_port_decoder.v ====
// One port's decode of the core event output onto its sixteen pins
`timescale 1ns/10ps
module event_port_decoder #(
  parameter [2:0] PORT_CODE = 3'h0
) (
  // Event control fields
  input  wire        gate,
  input  wire [2:0]  port_index,
  input  wire [3:0]  pin_index,
  input  wire        event_level,
  // Pin side
  output wire [15:0] pin_out,
  output wire [15:0] pin_oe
);
  wire hit;
  assign hit     = gate & (port_index == PORT_CODE);
  assign pin_oe  = hit ? (16'h0001 << pin_index) : 16'h0000;
  assign pin_out = pin_oe & {16{event_level}};
endmodule // event_port_decoder

// ==== tb/alt_function_router_chk.sv ====
// Port checker for the alternate function pin router
`timescale 1ns/10ps
module alt_function_router_chk #(
  parameter NUM_PORTS = 7
) (
  // Clock and reset
  input wire                    ref_clk,
  input wire                    rst_n,
  // Register port
  input wire                    bus_clk_en,
  input wire                    reg_sel,
  input wire                    reg_write,
  input wire [4:0]              reg_addr,
  input wire [31:0]             reg_wdata,
  input wire [31:0]             reg_rdata,
  input wire                    reg_ready,
  input wire                    reg_error,
  input wire [31:0]             remap_second,
  // Pin steering
  input wire [NUM_PORTS*16-1:0] event_pin_oe,
  input wire                    audio_enable,
  input wire                    audio_transmit,
  input wire                    audio_master_mode,
  input wire                    audio_serial_data_pin_oe,
  input wire                    audio_master_clock_pin_free,
  input wire                    usb_device_module_enable,
  input wire                    usb_pins_to_transceiver,
  input wire                    can_enable,
  input wire                    can_tx_pin_oe,
  input wire                    low_speed_crystal_clock_on,
  input wire                    slow_crystal_pins_gpio,
  input wire [1:0]              port_d_low_irq_out
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire take = reg_sel && bus_clk_en;
  wire evw  = take && reg_write && reg_addr == 5'h00;
  a_ready_follows: assert property (take |=> reg_ready) else $error("no ready");
  a_gated_bus: assert property (!take |=> !reg_ready) else $error("stray ready");
  a_unmapped_err: assert property (reg_ready |-> reg_error ==
    ($past(reg_addr) > 5'h18 || $past(reg_addr[1:0]) != 2'b00)) else $error("error flag");
  a_rsvd_zero: assert property (take && !reg_write && reg_addr == 5'h00
    |=> reg_rdata[31:8] == 24'h00_0000) else $error("reserved bits");
  a_event_on: assert property (evw && reg_wdata[7] && reg_wdata[6:4] != 3'h7
    |-> ##2 $onehot(event_pin_oe)) else $error("event pin");
  a_event_off: assert property (evw && (!reg_wdata[7] || reg_wdata[6:4] == 3'h7)
    |-> ##2 event_pin_oe == '0) else $error("event off");
  a_audio_dir: assert property (audio_serial_data_pin_oe == $past(audio_enable && audio_transmit)
    && audio_master_clock_pin_free == !$past(audio_enable && audio_master_mode)) else $error("audio");
  a_usb_follow: assert property (usb_pins_to_transceiver == $past(usb_device_module_enable)) else $error("usb");
  a_can_drive: assert property (can_tx_pin_oe == $past(can_enable)) else $error("can");
  a_slow_gpio: assert property (slow_crystal_pins_gpio == !$past(low_speed_crystal_clock_on)) else $error("lse");
  a_irq_block: assert property (remap_second[0] |=> port_d_low_irq_out == 2'b00) else $error("irq");
  c_event: cover property (evw && reg_wdata[7]);
  c_unmapped: cover property (reg_ready && reg_error);
  c_remap: cover property (remap_second[0]);
endmodule // alt_function_router_chk
bind alt_function_router alt_function_router_chk #(.NUM_PORTS(NUM_PORTS)) chk (.*);

// ==== tb/pin_partner.sv ====
// Far side model: external pin drivers and core event source
`timescale 1ns/10ps
module pin_partner (
  input  wire       ref_clk,
  output reg        core_event_signal,
  output reg        audio_serial_data_pin_in,
  output reg        can_rx_pin_in,
  output reg  [1:0] port_d_low_irq_in,
  // Peripheral side signals
  output reg        audio_master_clock,
  output reg        audio_data_out,
  output reg        can_tx
);
  reg [3:0] cnt = 4'h0;
  initial {audio_master_clock, audio_data_out, can_tx, core_event_signal, audio_serial_data_pin_in, can_rx_pin_in,
    port_d_low_irq_in} = 8'h18;
  // Pins change at different rates, the fastest every cycle, so a stale capture inside the router shows up
  always @(negedge ref_clk) begin
    cnt <= cnt + 4'h1;
    audio_serial_data_pin_in <= cnt[0];
    can_rx_pin_in <= ~cnt[1];
    port_d_low_irq_in <= cnt[3:2];
    core_event_signal <= ~cnt[0];
    audio_data_out <= cnt[1];
    audio_master_clock <= cnt[2] ^ cnt[0];
    can_tx <= cnt[3];
  end
endmodule // pin_partner

// ==== tb/tb_top.sv ====
// Testbench for the alternate function pin router
`timescale 1ns/10ps
module tb_top;
  reg          ref_clk = 1'b0, rst_n = 1'b0, bus_clk_en = 1'b1, reg_sel = 1'b0, reg_write = 1'b0, cap_sd, cap_rx;
  reg  [4:0]   reg_addr = 5'h00;
  reg  [31:0]  reg_wdata = 32'h0000_0000, rd, pat;
  reg  [5:0]   pi = 6'h00;
  reg  [1:0]   re, cap_irq;
  reg          cap_ev, cap_mck, cap_do, cap_tx;
  wire         core_event_signal, audio_serial_data_pin_in, can_rx_pin_in, reg_ready, reg_error, can_rx;
  wire         audio_serial_data_pin_oe, audio_data_in, audio_master_clock_pin_free, can_tx_pin_oe;
  wire         usb_pins_to_transceiver, slow_crystal_pins_gpio, main_crystal_pins_port_d;
  wire         audio_master_clock, audio_data_out, can_tx, audio_serial_data_pin_out, audio_master_clock_pin_out;
  wire         audio_master_clock_pin_oe, can_tx_pin_out;
  wire [1:0]   port_d_low_irq_in, port_d_low_irq_out;
  wire [31:0]  reg_rdata, remap_first, remap_second;
  wire [127:0] ext_irq_select;
  wire [111:0] event_pin_out, event_pin_oe;
  integer      err_total = 0, tests_run = 0, i, j;
  always #2.5 ref_clk = ~ref_clk;
  pin_partner far (.*);
  alt_function_router dut (.audio_enable(pi[0]), .audio_master_mode(pi[1]), .audio_transmit(pi[2]),
    .can_enable(pi[3]), .usb_device_module_enable(pi[4]), .low_speed_crystal_clock_on(pi[5]), .*);
  task check(input [31:0] seen, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
    end
  endtask
  // Request held over the taking edge only; a held select would be taken twice.
  // The one-cycle answer is read mid-cycle while it stands, then one idle cycle passes.
  task acc(input w, input [4:0] a, input [31:0] d);
    begin
      reg_sel = 1'b1;
      reg_write = w;
      reg_addr = a;
      reg_wdata = d;
      @(negedge ref_clk);
      rd = reg_rdata;
      re = {reg_ready, reg_error};
      reg_sel = 1'b0;
      @(negedge ref_clk);
    end
  endtask
  task t_regs;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        pat = 32'hc3a5_5ae6 ^ i;
        acc(1'b0, {i[2:0], 2'b00}, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        check(re, (i == 7) ? 2'b11 : 2'b10);
        acc(1'b1, {i[2:0], 2'b00}, pat);
        acc(1'b0, {i[2:0], 2'b00}, 32'h0000_0000);
        check(rd, (i == 0) ? pat & 32'h0000_00ff : (i == 7) ? 32'h0000_0000 : pat);
      end
      bus_clk_en = 1'b0;
      acc(1'b1, 5'h04, 32'h0000_0000);
      check(rd, 32'h0000_0000);
      check(re, 32'h0000_0000);
      bus_clk_en = 1'b1;
      acc(1'b0, 5'h04, 32'h0000_0000);
      check(rd, 32'hc3a5_5ae7);
      check(remap_first, 32'hc3a5_5ae7);
      check(remap_second, 32'hc3a5_5ae0);
      for (j = 0; j < 4; j = j + 1)
        check(ext_irq_select[j*32 +: 32], 32'hc3a5_5ae6 ^ (j + 2));
    end
  endtask
  task t_event;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        acc(1'b1, 5'h00, {24'h00_0000, 1'b1, i[2:0], i[2:0], 1'b1});
        @(posedge ref_clk) cap_ev = core_event_signal;
        @(negedge ref_clk);
        for (j = 0; j < 7; j = j + 1)
          check({event_pin_oe[j*16 +: 16], event_pin_out[j*16 +: 16]},
            (i == j) ? {16'h0001 << (i * 2 + 1), (16'h0001 << (i * 2 + 1)) & {16{cap_ev}}}
                     : 32'h0000_0000);
      end
      acc(1'b1, 5'h00, 32'h0000_0035);
      @(negedge ref_clk);
      check(|event_pin_oe, 1'b0);
    end
  endtask
  task t_periph;
    begin
      for (i = 0; i < 64; i = i + 1) begin
        pi = i;
        @(posedge ref_clk) cap_sd = audio_serial_data_pin_in;
        cap_rx = can_rx_pin_in;
        cap_do = audio_data_out;
        cap_mck = audio_master_clock;
        cap_tx = can_tx;
        @(negedge ref_clk);
        check({audio_serial_data_pin_oe, audio_data_in, audio_master_clock_pin_free, can_tx_pin_oe, can_rx,
          usb_pins_to_transceiver, slow_crystal_pins_gpio}, {pi[0] & pi[2], pi[0] & ~pi[2] & cap_sd,
          ~(pi[0] & pi[1]), pi[3], ~pi[3] | cap_rx, pi[4], ~pi[5]});
        check({audio_serial_data_pin_out, audio_master_clock_pin_oe, audio_master_clock_pin_out, can_tx_pin_out},
          {pi[0] & pi[2] & cap_do, pi[0] & pi[1], pi[0] & pi[1] & cap_mck, ~pi[3] | cap_tx});
      end
    end
  endtask
  task t_irq;
    begin
      for (i = 1; i >= 0; i = i - 1) begin
        acc(1'b1, 5'h18, i);
        @(negedge ref_clk);
        @(posedge ref_clk) cap_irq = port_d_low_irq_in;
        @(negedge ref_clk);
        check({main_crystal_pins_port_d, port_d_low_irq_out}, {i[0], i[0] ? 2'b00 : cap_irq});
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  initial begin
    repeat (6) @(negedge ref_clk);
    rst_n = 1'b1;
    t_regs;
    t_event;
    t_periph;
    t_irq;
    tally_and_finish;
  end
  initial begin
    #20000;
    err_total = err_total + 1;
    tally_and_finish;
  end
endmodule // tb_top
